// ---- rtl/simd_halving_abs_narrow_alu.sv ----
// one-stage execution datapath for halving, carry, reduce, abs and narrowing ops
// assumes the pipeline issues one decoded op per cycle and always accepts results
//
// Overview of operation
// - halving pair subtract: each halfword difference arithmetically shifted right one.
// - rounding halving subtracts add one before halving instead of truncating.
// - halving word subtract: full 33-bit difference arithmetically shifted right one.
// - all ops but byte sum sign-extend result bit 31 to 64 bits.
// - add-set-carry writes sum and records carry out into the carry flag.
// - add-with-carry adds both words plus carry flag, writes only result.
// - circular decrement subtracts decrement; on underflow loads reset value instead.
// - byte sum adds four low unsigned bytes, zero-extended to 64 bits.
// - quad byte abs saturates -1.0 to largest positive Q7.
// - pair halfword abs saturates -1.0 to largest positive Q15.
// - word abs saturates -1.0 to largest positive Q31.
// - integer narrow keeps low byte of each of four halfwords.
// - source a low halfwords fill the two upper byte lanes.
// - fractional narrow keeps upper byte; source a fills upper lanes.
// - shift-narrow arithmetically shifts both words right by the shift amount.
// - rounding shift-narrow adds one at the top discarded bit first.
// - low 16 bits of each shifted word go to source-b register lanes.
`timescale 1ns/1ps
module simd_halving_abs_narrow_alu (
    // clock and reset
    input  wire logic                     CLK,
    input  wire logic                     RST_N,
    // issue from the pipeline
    input  wire simd_alu_pkg::issue_type  ISSUE,
    // carry flag write from the pipeline
    input  wire logic                     CARRY_LOAD,
    input  wire logic                     CARRY_LOAD_VALUE,
    // result to the pipeline
    output simd_alu_pkg::result_type      RESULT,
    output logic                          CARRY_FLAG
);

    // ------------------------------------------------------------------
    // operand views
    // ------------------------------------------------------------------
    wire logic [31:0] a = ISSUE.src_a[31:0];
    wire logic [31:0] b = ISSUE.src_b[31:0];
    wire simd_alu_pkg::op_type op = ISSUE.op;

    wire logic round_ph = (op == simd_alu_pkg::OP_HSUB_R_PH);
    wire logic round_w  = (op == simd_alu_pkg::OP_HSUB_R_W);

    // ------------------------------------------------------------------
    // halving subtract, per halfword lane
    // ------------------------------------------------------------------
    logic [31:0] hsub_ph;
    genvar gh;
    generate
        for (gh = 0; gh < 2; gh++) begin : g_hsub
            wire logic signed [17:0] diff = 18'($signed(a[gh*16 +: 16])) - 18'($signed(b[gh*16 +: 16]));
            wire logic signed [17:0] adj  = diff + {17'h0_0000, round_ph};
            assign hsub_ph[gh*16 +: 16] = adj[16:1];
        end
    endgenerate

    // ------------------------------------------------------------------
    // halving subtract, word; guard bits hold the full difference
    // ------------------------------------------------------------------
    wire logic signed [33:0] wdiff  = 34'($signed(a)) - 34'($signed(b));
    wire logic signed [33:0] wadj   = wdiff + {33'h0_0000_0000, round_w};
    wire logic [31:0]        hsub_w = wadj[32:1];

    // ------------------------------------------------------------------
    // additions with carry flag
    // ------------------------------------------------------------------
    wire logic [32:0] sum_sc = {1'b0, a} + {1'b0, b};
    wire logic [31:0] sum_wc = a + b + {31'h0000_0000, CARRY_FLAG};

    // ------------------------------------------------------------------
    // circular index decrement
    // ------------------------------------------------------------------
    wire logic [7:0]  mod_dec   = b[simd_alu_pkg::CIRCULAR_INDEX_DECREMENT_DEC_LSB +: simd_alu_pkg::CIRCULAR_INDEX_DECREMENT_DEC_W];
    wire logic [15:0] mod_rst   = b[simd_alu_pkg::CIRCULAR_INDEX_DECREMENT_RST_LSB +: simd_alu_pkg::CIRCULAR_INDEX_DECREMENT_RST_W];
    wire logic [32:0] mod_diff  = {1'b0, a} - {25'h000_0000, mod_dec};
    wire logic        mod_under = mod_diff[32];
    wire logic [31:0] mod_res   = mod_under ? {16'h0000, mod_rst} : mod_diff[31:0];

    // ------------------------------------------------------------------
    // byte reduction
    // ------------------------------------------------------------------
    wire logic [9:0] byte_sum = {2'b00, a[7:0]} + {2'b00, a[15:8]}
                              + {2'b00, a[23:16]} + {2'b00, a[31:24]};

    // ------------------------------------------------------------------
    // saturating absolute values
    // ------------------------------------------------------------------
    logic [31:0] abs_qb;
    logic [31:0] abs_ph;
    logic [31:0] abs_w;
    genvar gb;
    generate
        for (gb = 0; gb < 4; gb++) begin : g_abs_qb
            abs_sat #(.W(8)) u_abs (.value(b[gb*8 +: 8]), .magnitude(abs_qb[gb*8 +: 8]));
        end
        for (gb = 0; gb < 2; gb++) begin : g_abs_ph
            abs_sat #(.W(16)) u_abs (.value(b[gb*16 +: 16]), .magnitude(abs_ph[gb*16 +: 16]));
        end
    endgenerate
    abs_sat #(.W(32)) u_abs_w (.value(b), .magnitude(abs_w));

    // ------------------------------------------------------------------
    // narrowing; source a always lands in the upper lanes
    // ------------------------------------------------------------------
    wire logic [31:0] narrow_int  = {a[23:16], a[7:0], b[23:16], b[7:0]};
    wire logic [31:0] narrow_frac = {a[31:24], a[15:8], b[31:24], b[15:8]};

    // ------------------------------------------------------------------
    // shift and narrow word pair to halfwords
    // ------------------------------------------------------------------
    wire logic        round_sh = (op == simd_alu_pkg::OP_SHIFT_NARROW_R);
    logic [31:0]      sh_hi;
    logic [31:0]      sh_lo;
    shift_round #(.W(32), .SW(simd_alu_pkg::SHAMT_W)) u_sh_hi (
        .value   (b),
        .amount  (ISSUE.shamt),
        .round   (round_sh),
        .shifted (sh_hi)
    );
    shift_round #(.W(32), .SW(simd_alu_pkg::SHAMT_W)) u_sh_lo (
        .value   (a),
        .amount  (ISSUE.shamt),
        .round   (round_sh),
        .shifted (sh_lo)
    );
    wire logic [31:0] shift_narrow = {sh_hi[15:0], sh_lo[15:0]};

    // ------------------------------------------------------------------
    // result select; flat decode feeds a priority chain, so later ops pass more mux levels
    // ------------------------------------------------------------------
    wire logic is_hsub_ph = (op == simd_alu_pkg::OP_HSUB_PH) || round_ph;
    wire logic is_hsub_w  = (op == simd_alu_pkg::OP_HSUB_W) || round_w;
    wire logic is_sc      = (op == simd_alu_pkg::OP_ADD_SET_CARRY);
    wire logic is_wc      = (op == simd_alu_pkg::OP_ADD_WITH_CARRY);
    wire logic is_mod     = (op == simd_alu_pkg::OP_CIRCULAR_INDEX_DECREMENT);
    wire logic is_sum     = (op == simd_alu_pkg::OP_BYTE_SUM);
    wire logic is_sh      = (op == simd_alu_pkg::OP_SHIFT_NARROW) || round_sh;

    wire logic [31:0] r32 =
        is_hsub_ph                                  ? hsub_ph      :
        is_hsub_w                                   ? hsub_w       :
        is_sc                                       ? sum_sc[31:0] :
        is_wc                                       ? sum_wc       :
        is_mod                                      ? mod_res      :
        (op == simd_alu_pkg::OP_ABS_QB)             ? abs_qb       :
        (op == simd_alu_pkg::OP_ABS_PH)             ? abs_ph       :
        (op == simd_alu_pkg::OP_ABS_W)              ? abs_w        :
        (op == simd_alu_pkg::OP_NARROW_QB)          ? narrow_int   :
        (op == simd_alu_pkg::OP_NARROW_FRAC_QB)     ? narrow_frac  :
        is_sh                                       ? shift_narrow :
                                                      32'h0000_0000;

    wire logic [63:0] next_data = is_sum ? {54'h0_0000_0000_0000, byte_sum}
                                         : {{32{r32[31]}}, r32};

    // carry from the datapath beats a same-cycle load from the pipeline
    wire logic sc_fire    = ISSUE.valid && is_sc;
    wire logic next_carry = sc_fire ? sum_sc[32] : (CARRY_LOAD ? CARRY_LOAD_VALUE : CARRY_FLAG);

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            RESULT.valid       <= 1'b0;
            RESULT.data        <= simd_alu_pkg::RESULT_RESET;
            RESULT.dest_is_b   <= 1'b0;
            RESULT.carry_write <= 1'b0;
        end else begin
            RESULT.valid       <= ISSUE.valid;
            RESULT.data        <= ISSUE.valid ? next_data : RESULT.data;
            RESULT.dest_is_b   <= ISSUE.valid && is_sh;
            RESULT.carry_write <= sc_fire;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            CARRY_FLAG <= simd_alu_pkg::CARRY_RESET;
        end else begin
            CARRY_FLAG <= next_carry;
        end
    end

    // ------------------------------------------------------------------
    // checks: helper copy of the issued op, read only by assertions
    // ------------------------------------------------------------------
    simd_alu_pkg::issue_type iq;
    logic                    cq;
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            iq <= '0;
            cq <= 1'b0;
        end else begin
            iq <= ISSUE;
            cq <= CARRY_FLAG;
        end
    end

    wire logic [31:0] qa = iq.src_a[31:0];
    wire logic [31:0] qb = iq.src_b[31:0];
    wire logic        ok = RESULT.valid;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    a_hsub_pair_half: assert property (ok && iq.op == simd_alu_pkg::OP_HSUB_PH |->
        RESULT.data[15:0] == 16'(($signed(17'($signed(qa[15:0]))) - $signed(17'($signed(qb[15:0])))) >>> 1)
        && RESULT.data[31:16] == 16'(($signed(17'($signed(qa[31:16]))) - $signed(17'($signed(qb[31:16])))) >>> 1))
        else $error("halving pair subtract wrong");

    a_round_half_up: assert property (ok && iq.op == simd_alu_pkg::OP_HSUB_R_W |->
        RESULT.data[31:0] == 32'(($signed(34'($signed(qa))) - $signed(34'($signed(qb))) + 34'sd1) >>> 1))
        else $error("rounding halving word subtract wrong");

    a_hsub_word_trunc: assert property (ok && iq.op == simd_alu_pkg::OP_HSUB_W |->
        RESULT.data[31:0] == 32'(($signed(34'($signed(qa))) - $signed(34'($signed(qb)))) >>> 1))
        else $error("halving word subtract wrong");

    a_sign_extend_top: assert property (ok && iq.op != simd_alu_pkg::OP_BYTE_SUM |->
        RESULT.data[63:32] == {32{RESULT.data[31]}})
        else $error("upper word not sign extension");

    a_carry_records: assert property (ISSUE.valid && ISSUE.op == simd_alu_pkg::OP_ADD_SET_CARRY |=>
        RESULT.carry_write && {CARRY_FLAG, RESULT.data[31:0]} == 33'({1'b0, qa} + {1'b0, qb}))
        else $error("carry out not recorded");

    a_carry_consumed: assert property (ok && iq.op == simd_alu_pkg::OP_ADD_WITH_CARRY |->
        RESULT.data[31:0] == 32'(qa + qb + {31'h0000_0000, cq}) && !RESULT.carry_write)
        else $error("add with carry wrong");

    a_circular_index_decrement_wrap: assert property (ok && iq.op == simd_alu_pkg::OP_CIRCULAR_INDEX_DECREMENT |->
        RESULT.data[31:0] == ((qa < {24'h00_0000, qb[7:0]}) ? {16'h0000, qb[23:8]} : qa - {24'h00_0000, qb[7:0]}))
        else $error("circular decrement wrong");

    a_byte_sum_zext: assert property (ok && iq.op == simd_alu_pkg::OP_BYTE_SUM |->
        RESULT.data == 64'(qa[7:0]) + 64'(qa[15:8]) + 64'(qa[23:16]) + 64'(qa[31:24]))
        else $error("byte sum wrong");

    a_abs_byte_sat: assert property (ok && iq.op == simd_alu_pkg::OP_ABS_QB && qb[31:24] == 8'h80 |->
        RESULT.data[31:24] == 8'h7F && RESULT.data[63:32] == 32'h0000_0000)
        else $error("byte abs not saturated");

    a_abs_half_val: assert property (ok && iq.op == simd_alu_pkg::OP_ABS_PH |->
        RESULT.data[15:0] == ((qb[15:0] == 16'h8000) ? 16'h7FFF : (qb[15] ? 16'(-qb[15:0]) : qb[15:0])))
        else $error("halfword abs wrong");

    a_abs_word_sat: assert property (ok && iq.op == simd_alu_pkg::OP_ABS_W |->
        RESULT.data[31:0] == ((qb == 32'h8000_0000) ? 32'h7FFF_FFFF : (qb[31] ? 32'(-qb) : qb)))
        else $error("word abs wrong");

    a_narrow_int_lanes: assert property (ok && iq.op == simd_alu_pkg::OP_NARROW_QB |->
        RESULT.data[31:24] == qa[23:16] && RESULT.data[23:16] == qa[7:0]
        && RESULT.data[15:8] == qb[23:16] && RESULT.data[7:0] == qb[7:0])
        else $error("integer narrow lanes wrong");

    a_narrow_frac_lanes: assert property (ok && iq.op == simd_alu_pkg::OP_NARROW_FRAC_QB |->
        RESULT.data[31:16] == {qa[31:24], qa[15:8]} && RESULT.data[15:0] == {qb[31:24], qb[15:8]})
        else $error("fractional narrow lanes wrong");

    a_shift_narrow_trunc: assert property (ok && iq.op == simd_alu_pkg::OP_SHIFT_NARROW |->
        RESULT.dest_is_b && RESULT.data[31:16] == 16'($signed(qb) >>> iq.shamt)
        && RESULT.data[15:0] == 16'($signed(qa) >>> iq.shamt))
        else $error("shift narrow wrong");

    a_shift_round_bias: assert property (ok && iq.op == simd_alu_pkg::OP_SHIFT_NARROW_R
        && iq.shamt != 5'h0_0 |->
        RESULT.data[15:0] == 16'(($signed(qa) >>> (iq.shamt - 5'h0_1)) + 33'sd1 >>> 1))
        else $error("rounded shift narrow wrong");

    a_shift_round_high: assert property (ok && iq.op == simd_alu_pkg::OP_SHIFT_NARROW_R
        && iq.shamt != 5'h0_0 |->
        RESULT.data[31:16] == 16'(($signed(qb) >>> (iq.shamt - 5'h0_1)) + 33'sd1 >>> 1))
        else $error("rounded shift narrow high wrong");

    a_hsub_pair_round: assert property (ok && iq.op == simd_alu_pkg::OP_HSUB_R_PH |->
        RESULT.data[15:0] == 16'(($signed(18'($signed(qa[15:0]))) - $signed(18'($signed(qb[15:0]))) + 18'sd1) >>> 1))
        else $error("rounding halving pair subtract wrong");

    a_abs_byte_val: assert property (ok && iq.op == simd_alu_pkg::OP_ABS_QB |->
        RESULT.data[7:0] == ((qb[7:0] == 8'h80) ? 8'h7F : (qb[7] ? 8'(-qb[7:0]) : qb[7:0])))
        else $error("byte abs wrong");

    a_dest_b_only_shift: assert property (RESULT.dest_is_b |-> ok
        && iq.op inside {simd_alu_pkg::OP_SHIFT_NARROW, simd_alu_pkg::OP_SHIFT_NARROW_R})
        else $error("destination select wrong");

    a_wc_keeps_carry: assert property (ISSUE.valid && !CARRY_LOAD
        && ISSUE.op == simd_alu_pkg::OP_ADD_WITH_CARRY |=> CARRY_FLAG == cq)
        else $error("add with carry changed carry flag");

    c_carry_chain: cover property (ISSUE.valid && ISSUE.op == simd_alu_pkg::OP_ADD_SET_CARRY
        ##1 ISSUE.valid && ISSUE.op == simd_alu_pkg::OP_ADD_WITH_CARRY && CARRY_FLAG);
    c_circular_index_decrement_wrap: cover property (ok && iq.op == simd_alu_pkg::OP_CIRCULAR_INDEX_DECREMENT && qa < {24'h00_0000, qb[7:0]});
    c_abs_word_min: cover property (ok && iq.op == simd_alu_pkg::OP_ABS_W && qb == 32'h8000_0000);
    c_round_shift: cover property (ok && iq.op == simd_alu_pkg::OP_SHIFT_NARROW_R && iq.shamt != 5'h0_0);
    c_hsub_round_pair: cover property (ok && iq.op == simd_alu_pkg::OP_HSUB_R_PH);

endmodule : simd_halving_abs_narrow_alu

// ---- rtl/simd_alu_pkg.sv ----
// constants, opcodes and carrier structs for the packed-arithmetic datapath
// assumes the host pipeline decodes instructions into op_type before issue
package simd_alu_pkg;

    // ------------------------------------------------------------------
    // widths
    // ------------------------------------------------------------------
    localparam int XLEN    = 64;
    localparam int WLEN    = 32;
    localparam int HLEN    = 16;
    localparam int BLEN    = 8;
    localparam int SHAMT_W = 5;
    localparam int SUM_W   = 10;

    // ------------------------------------------------------------------
    // circular index operand layout inside source b
    // ------------------------------------------------------------------
    localparam int CIRCULAR_INDEX_DECREMENT_DEC_LSB = 0;
    localparam int CIRCULAR_INDEX_DECREMENT_DEC_W   = 8;
    localparam int CIRCULAR_INDEX_DECREMENT_RST_LSB = 8;
    localparam int CIRCULAR_INDEX_DECREMENT_RST_W   = 16;

    // ------------------------------------------------------------------
    // reset values and timing
    // ------------------------------------------------------------------
    localparam logic [63:0] RESULT_RESET   = 64'h0000_0000_0000_0000;
    localparam logic        CARRY_RESET    = 1'b0;
    localparam int          LATENCY_CYCLES = 1;

    // ------------------------------------------------------------------
    // operations and carriers
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        OP_HSUB_PH,
        OP_HSUB_R_PH,
        OP_HSUB_W,
        OP_HSUB_R_W,
        OP_ADD_SET_CARRY,
        OP_ADD_WITH_CARRY,
        OP_CIRCULAR_INDEX_DECREMENT,
        OP_BYTE_SUM,
        OP_ABS_QB,
        OP_ABS_PH,
        OP_ABS_W,
        OP_NARROW_QB,
        OP_NARROW_FRAC_QB,
        OP_SHIFT_NARROW,
        OP_SHIFT_NARROW_R
    } op_type;

    typedef struct packed {
        logic              valid;
        op_type            op;
        logic [XLEN-1:0]   src_a;
        logic [XLEN-1:0]   src_b;
        logic [SHAMT_W-1:0] shamt;
    } issue_type;

    typedef struct packed {
        logic            valid;
        logic [XLEN-1:0] data;
        logic            dest_is_b;
        logic            carry_write;
    } result_type;

endpackage : simd_alu_pkg

// ---- rtl/abs_sat.sv ----
// saturating absolute value of one signed fractional lane
// pure combinational; width set by parameter W at each instance
`timescale 1ns/1ps
module abs_sat #(
    parameter int W = 8
) (
    // lane in and out
    input  wire logic [W-1:0] value,
    output logic      [W-1:0] magnitude
);

    // ------------------------------------------------------------------
    // -1.0 has no positive twin, so it clamps to the largest value
    // ------------------------------------------------------------------
    wire logic         is_min  = (value == {1'b1, {(W-1){1'b0}}});
    wire logic [W-1:0] negated = ~value + {{(W-1){1'b0}}, 1'b1};

    assign magnitude = is_min ? {1'b0, {(W-1){1'b1}}} : (value[W-1] ? negated : value);

endmodule : abs_sat

// ---- rtl/shift_round.sv ----
// arithmetic right shift of one word with optional round-half-up
// pure combinational; amount of zero never rounds
`timescale 1ns/1ps
module shift_round #(
    parameter int W  = 32,
    parameter int SW = 5
) (
    // operand and control
    input  wire logic [W-1:0]  value,
    input  wire logic [SW-1:0] amount,
    input  wire logic          round,
    // shifted word
    output logic      [W-1:0]  shifted
);

    // ------------------------------------------------------------------
    // one guard bit keeps the rounding add from wrapping
    // ------------------------------------------------------------------
    wire logic signed [W:0] ext  = {value[W-1], value};
    wire logic signed [W:0] bias = (round && amount != '0) ?
                                   ((W+1)'(1) << (amount - {{(SW-1){1'b0}}, 1'b1})) : '0;
    wire logic signed [W:0] sum  = ext + bias;

    assign shifted = W'(sum >>> amount);

endmodule : shift_round

// ---- verification/pipe_issuer.sv ----
// pipeline-side model: presents decoded ops and carry loads to the datapath
// assumes the bench calls drive once per clock; the datapath never stalls
`timescale 1ns/1ps
module pipe_issuer (
    // clock
    input  wire logic                CLK,
    // issue side
    output simd_alu_pkg::issue_type  ISSUE,
    output logic                     CARRY_LOAD,
    output logic                     CARRY_LOAD_VALUE
);
    initial begin
        ISSUE = '0;
        CARRY_LOAD = 1'b0;
        CARRY_LOAD_VALUE = 1'b0;
    end
    // no ready signal, so a request lives exactly one edge
    task automatic drive(input simd_alu_pkg::issue_type nx, input logic ld, input logic lv);
        @(posedge CLK);
        ISSUE <= nx;
        CARRY_LOAD <= ld;
        CARRY_LOAD_VALUE <= lv;
    endtask : drive
endmodule : pipe_issuer

// ---- verification/simd_halving_abs_narrow_alu_bench.sv ----
// self-checking bench: random and corner ops against an integer model
// assumes one-cycle result latency and the carry flag kept inside the block
`timescale 1ns/1ps
module simd_halving_abs_narrow_alu_bench;
    logic                      clk;
    logic                      rst_n;
    simd_alu_pkg::issue_type   issue;
    logic                      ld;
    logic                      lv;
    simd_alu_pkg::result_type  res;
    logic                      cflag;
    int                        n_errors;
    int                        n_tests;
    simd_alu_pkg::issue_type   prev;
    logic                      prev_ld;
    logic                      prev_lv;
    logic                      cf;
    logic [63:0]               last;
    logic [31:0]               cor [4];

    pipe_issuer P (.CLK(clk), .ISSUE(issue), .CARRY_LOAD(ld), .CARRY_LOAD_VALUE(lv));
    simd_halving_abs_narrow_alu DUT (.CLK(clk), .RST_N(rst_n), .ISSUE(issue), .CARRY_LOAD(ld),
        .CARRY_LOAD_VALUE(lv), .RESULT(res), .CARRY_FLAG(cflag));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // ----------------------------------------
    // reference model
    // ----------------------------------------
    function automatic logic [63:0] model(input simd_alu_pkg::issue_type i, input logic c);
        logic [31:0] a;
        logic [31:0] b;
        logic [31:0] r;
        longint      x;
        longint      y;
        int          w;
        a = i.src_a[31:0];
        b = i.src_b[31:0];
        r = '0;
        case (i.op)
            simd_alu_pkg::OP_HSUB_PH, simd_alu_pkg::OP_HSUB_R_PH:
                for (int k = 0; k < 2; k++) begin
                    x = longint'($signed(a[16*k+:16])) - longint'($signed(b[16*k+:16]));
                    x = (x + longint'(i.op == simd_alu_pkg::OP_HSUB_R_PH)) >>> 1;
                    r[16*k+:16] = x[15:0];
                end
            simd_alu_pkg::OP_HSUB_W, simd_alu_pkg::OP_HSUB_R_W: begin
                x = longint'($signed(a)) - longint'($signed(b));
                x = (x + longint'(i.op == simd_alu_pkg::OP_HSUB_R_W)) >>> 1;
                r = x[31:0];
            end
            simd_alu_pkg::OP_ADD_SET_CARRY: r = a + b;
            simd_alu_pkg::OP_ADD_WITH_CARRY: r = a + b + c;
            simd_alu_pkg::OP_CIRCULAR_INDEX_DECREMENT: r = (a < b[7:0]) ? {16'h0000, b[23:8]} : a - b[7:0];
            simd_alu_pkg::OP_BYTE_SUM: return a[7:0] + a[15:8] + a[23:16] + a[31:24];
            simd_alu_pkg::OP_ABS_QB, simd_alu_pkg::OP_ABS_PH, simd_alu_pkg::OP_ABS_W: begin
                w = i.op == simd_alu_pkg::OP_ABS_QB ? 8 : i.op == simd_alu_pkg::OP_ABS_PH ? 16 : 32;
                for (int k = 0; k < 32; k += w) begin
                    x = (longint'(b) >> k) & ((64'sd1 << w) - 1);
                    if (x >= (64'sd1 << (w - 1))) x = (64'sd1 << w) - x;
                    if (x == (64'sd1 << (w - 1))) x = x - 1;
                    r = r | 32'(x << k);
                end
            end
            simd_alu_pkg::OP_NARROW_QB: r = {a[23:16], a[7:0], b[23:16], b[7:0]};
            simd_alu_pkg::OP_NARROW_FRAC_QB: r = {a[31:24], a[15:8], b[31:24], b[15:8]};
            simd_alu_pkg::OP_SHIFT_NARROW, simd_alu_pkg::OP_SHIFT_NARROW_R: begin
                w = int'(i.shamt);
                y = (i.op == simd_alu_pkg::OP_SHIFT_NARROW_R && w > 0) ? 64'sd1 <<< (w - 1) : 0;
                x = (longint'($signed(b)) + y) >>> w;
                r[31:16] = x[15:0];
                x = (longint'($signed(a)) + y) >>> w;
                r[15:0] = x[15:0];
            end
            default: r = '0;
        endcase
        return {{32{r[31]}}, r};
    endfunction : model

    function automatic simd_alu_pkg::issue_type mk(input int o, input logic [31:0] a, input logic [31:0] b,
                                                   input logic [4:0] sh);
        // random upper halves: the datapath must ignore them
        mk = '{1'b1, simd_alu_pkg::op_type'(o), {$urandom(), a}, {$urandom(), b}, sh};
    endfunction : mk

    task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    // drive next op, then judge the op taken at this same edge
    task automatic step(input simd_alu_pkg::issue_type nx, input logic l, input logic v);
        logic [32:0] s;
        P.drive(nx, l, v);
        #1;
        s = {1'b0, prev.src_a[31:0]} + prev.src_b[31:0];
        if (prev.valid) last = model(prev, cf);
        if (prev.valid && prev.op == simd_alu_pkg::OP_ADD_SET_CARRY) cf = s[32];
        else if (prev_ld) cf = prev_lv;
        check("valid", res.valid, prev.valid);
        check("data", res.data, last);
        check("dest_b", res.dest_is_b, prev.valid && prev.op inside {simd_alu_pkg::OP_SHIFT_NARROW,
              simd_alu_pkg::OP_SHIFT_NARROW_R});
        check("carry_wr", res.carry_write, prev.valid && prev.op == simd_alu_pkg::OP_ADD_SET_CARRY);
        check("carry", cflag, cf);
        prev = nx;
        prev_ld = l;
        prev_lv = v;
    endtask : step

    task automatic do_reset;
        P.drive('0, 1'b0, 1'b0);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        check("rst_data", res.data, simd_alu_pkg::RESULT_RESET);
        check("rst_carry", cflag, simd_alu_pkg::CARRY_RESET);
        @(posedge clk);
        rst_n <= 1'b1;
        prev = '0;
        prev_ld = 1'b0;
        prev_lv = 1'b0;
        last = simd_alu_pkg::RESULT_RESET;
        cf = simd_alu_pkg::CARRY_RESET;
    endtask : do_reset

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        tally_and_finish();
    end

    initial begin
        rst_n = 1'b0;
        n_errors = 0;
        n_tests = 0;
        cor = '{32'h8000_8000, 32'h8080_8080, 32'h7FFF_FFFF, 32'h0000_0001};
        void'($urandom(35));
        do_reset();
        $display("test reset done");
        // carry set then consumed back to back; a load colliding with the set is dropped
        step(mk(4, 32'hFFFF_FFFF, 32'h0000_0001, 5'h00), 1'b0, 1'b0);
        step(mk(5, 32'h0000_0000, 32'h0000_0000, 5'h00), 1'b0, 1'b0);
        step(mk(4, 32'h0000_0000, 32'h0000_0000, 5'h00), 1'b1, 1'b1);
        step(mk(7, 32'h8080_8080, 32'h0000_0000, 5'h00), 1'b0, 1'b0);
        step('0, 1'b0, 1'b0);
        $display("test carry done");
        for (int o = 0; o < 15; o++) begin
            for (int k = 0; k < 4; k++) step(mk(o, cor[k], cor[3-k], 5'(k * 9)), 1'b0, 1'b0);
        end
        step('0, 1'b0, 1'b0);
        $display("test corners done");
        do_reset();
        for (int n = 0; n < 2000; n++) begin
            step($urandom_range(3) == 0 ? simd_alu_pkg::issue_type'('0) :
                 mk($urandom_range(14), $urandom_range(3) == 0 ? cor[$urandom_range(3)] : $urandom(),
                    $urandom_range(3) == 0 ? cor[$urandom_range(3)] : $urandom(), 5'($urandom())),
                 $urandom_range(3) == 0, 1'($urandom()));
        end
        step('0, 1'b0, 1'b0);
        $display("test random done");
        tally_and_finish();
    end
endmodule : simd_halving_abs_narrow_alu_bench
